// >>> core/t16pw_cfg.svh
`ifndef T16PW_CFG_SVH
`define T16PW_CFG_SVH

// Register word indices; byte address is four times the index.
`define T16PW_IX_CR1   6'h00
`define T16PW_IX_CR2   6'h01
`define T16PW_IX_SR    6'h02
`define T16PW_IX_IC1H  6'h03
`define T16PW_IX_IC1L  6'h04
`define T16PW_IX_OC1H  6'h05
`define T16PW_IX_OC1L  6'h06
`define T16PW_IX_OC2H  6'h07
`define T16PW_IX_OC2L  6'h08
`define T16PW_IX_CNTH  6'h09
`define T16PW_IX_CNTL  6'h0a
`define T16PW_IX_IC2H  6'h0b
`define T16PW_IX_IC2L  6'h0c
`define T16PW_IX_PWR   6'h0d
`define T16PW_IX_LSB   2
`define T16PW_IX_MSB   7

// Control one fields.
`define T16PW_CAPTURE_IRQ_ENABLE   7
`define T16PW_COMPARE_IRQ_ENABLE   6
`define T16PW_OVERFLOW_IRQ_ENABLE   5
`define T16PW_FOLV2  4
`define T16PW_FOLV1  3
`define T16PW_LEVEL_AFTER_MATCH_TWO  2
`define T16PW_CAPTURE_ONE_EDGE_SEL  1
`define T16PW_LEVEL_AFTER_MATCH_ONE  0
// Control two fields.
`define T16PW_COMPARE_ONE_PIN_ENABLE   7
`define T16PW_OC2E   6
`define T16PW_OPM    5
`define T16PW_PWM    4
`define T16PW_CC_MSB 3
`define T16PW_CC_LSB 2
`define T16PW_IEDG2  1
`define T16PW_EXEDG  0
// Flag register fields.
`define T16PW_F_CAPTURE_ONE_FLAG 4
`define T16PW_F_COMPARE_ONE_FLAG 3
`define T16PW_F_TOF  2
`define T16PW_F_CAPTURE_TWO_FLAG 1
`define T16PW_F_COMPARE_TWO_FLAG 0
// Power register fields.
`define T16PW_P_MASK 2

`define T16PW_CR_RST   8'h00
`define T16PW_OC_RST   16'h8000
`define T16PW_RELOAD   16'hfffc
`define T16PW_TRIG_CAP 16'hfffd
`define T16PW_CNT_TOP  16'hffff
`define T16PW_CC_DIV4  2'b00
`define T16PW_CC_DIV2  2'b01
`define T16PW_CC_DIV8  2'b10
`define T16PW_CC_EXT   2'b11
`define T16PW_LAST2    3'h1
`define T16PW_LAST4    3'h3
`define T16PW_LAST8    3'h7
`define T16PW_MSK2     3'h1
`define T16PW_MSK4     3'h3
`define T16PW_MSK8     3'h7
`endif

// >>> core/t16pw_pkg.sv
package t16pw_pkg;

    // Power state, Gray coded along run, wait, halt.
    typedef enum logic [1:0] {
        T16PW_RUN  = 2'b00,
        T16PW_WAIT = 2'b01,
        T16PW_HALT = 2'b11
    } t16pw_pwr_t;

    typedef struct packed {
        logic [7:0]  cr1;
        logic [7:0]  cr2;
        logic        capture_one_flag;
        logic        compare_one_flag;
        logic        overflow_flag;
        logic        capture_two_flag;
        logic        compare_two_flag;
        logic [4:0]  arm;
        logic [15:0] cnt;
        logic [15:0] ic1;
        logic [15:0] ic2;
        logic [15:0] oc1;
        logic [15:0] oc2;
        logic [2:0]  pre;
        logic        live;
        logic        cap1_q;
        logic        cap2_q;
        logic        ext_q;
        logic        ic1_inh;
        logic        ic2_inh;
        logic        oc1_inh;
        logic        oc2_inh;
        logic        harm1;
        logic        harm2;
        t16pw_pwr_t  pwr;
        logic        mask;
        logic        out1;
        logic        out2;
        logic        irq;
        logic        wake;
    } t16pw_core_t;

    typedef struct packed {
        logic        acc;
        logic        wr;
        logic [5:0]  idx;
        logic        ready;
        logic [31:0] rdata;
    } t16pw_bus_t;

endpackage

// >>> core/t16pw_reg_if.sv
`timescale 1ns/1ps
interface t16pw_reg_if;
    logic       acc;
    logic       wr;
    logic [5:0] idx;
    logic [7:0] wdata;
    logic [7:0] rdata;

    modport bus (output acc, output wr, output idx, output wdata, input rdata);
    modport core (input acc, input wr, input idx, input wdata, output rdata);
endinterface

// >>> core/t16pw_ahb.sv
`timescale 1ns/1ps
`include "t16pw_cfg.svh"
module t16pw_ahb (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    t16pw_reg_if.bus         rif
);
    import t16pw_pkg::*;

    t16pw_bus_t s;
    t16pw_bus_t n;

    // The access pulse falls in the first data-phase cycle; one wait state
    // lets the read data be registered before it is presented.
    always_comb begin
        n = s;
        n.acc = 1'b0;
        if (s.acc) begin
            n.rdata = {24'h0, rif.rdata};
            n.ready = 1'b1;
        end
        if (hsel && htrans[1] && hready) begin
            n.acc = 1'b1;
            n.wr = hwrite;
            n.idx = haddr[`T16PW_IX_MSB:`T16PW_IX_LSB];
            n.ready = 1'b0;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s <= '0;
            s.ready <= 1'b1;
        end else begin
            s <= n;
        end
    end

    assign rif.acc = s.acc;
    assign rif.wr = s.wr;
    assign rif.idx = s.idx;
    assign rif.wdata = hwdata[7:0];
    assign hrdata = s.rdata;
    assign hreadyout = s.ready;
endmodule

// >>> core/t16pw_timer.sv
// Added by the designer: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
`include "t16pw_cfg.svh"
module t16pw_timer (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        capture_one_pin,
    input  wire logic        capture_two_pin,
    input  wire logic        ext_clock_pin,
    input  wire logic        halt_wake,
    output logic             compare_one_pin,
    output logic             compare_one_pin_oe,
    output logic             compare_two_pin,
    output logic             compare_two_pin_oe,
    output logic             timer_irq,
    output logic             wake_req
);
    import t16pw_pkg::*;

    t16pw_core_t s;
    t16pw_core_t n;
    t16pw_reg_if rif ();

    t16pw_ahb u_ahb (
        .clock     (clock),
        .rst       (rst),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hwdata    (hwdata),
        .hready    (hready),
        .hrdata    (hrdata),
        .hreadyout (hreadyout),
        .rif       (rif)
    );

    function automatic logic t16pw_edge(input logic prev, input logic cur,
                                        input logic rise);
        return rise ? (!prev && cur) : (prev && !cur);
    endfunction

    function automatic logic [7:0] t16pw_byte(input logic [15:0] v, input logic hi);
        return hi ? v[15:8] : v[7:0];
    endfunction

    function automatic logic [4:0] t16pw_flags(input t16pw_core_t c);
        logic [4:0] f;
        f = '0;
        f[`T16PW_F_CAPTURE_ONE_FLAG] = c.capture_one_flag;
        f[`T16PW_F_COMPARE_ONE_FLAG] = c.compare_one_flag;
        f[`T16PW_F_TOF] = c.overflow_flag;
        f[`T16PW_F_CAPTURE_TWO_FLAG] = c.capture_two_flag;
        f[`T16PW_F_COMPARE_TWO_FLAG] = c.compare_two_flag;
        return f;
    endfunction

    always_comb begin
        logic       pwm;
        logic       single_pulse_select;
        logic       halted;
        logic       tick;
        logic       e1;
        logic       e2;
        logic       ex;
        logic       hit1;
        logic       hit2;
        logic       rd;
        logic       wr;
        logic [7:0] rdat;
        pwm = 1'b0;
        single_pulse_select = 1'b0;
        halted = 1'b0;
        tick = 1'b0;
        e1 = 1'b0;
        e2 = 1'b0;
        ex = 1'b0;
        hit1 = 1'b0;
        hit2 = 1'b0;
        rd = 1'b0;
        wr = 1'b0;
        rdat = 8'h00;
        n = s;
        n.wake = 1'b0;
        n.live = 1'b1;
        n.cap1_q = capture_one_pin;
        n.cap2_q = capture_two_pin;
        n.ext_q = ext_clock_pin;

        pwm = s.cr2[`T16PW_PWM];
        single_pulse_select = s.cr2[`T16PW_OPM] && !pwm;
        halted = (s.pwr == T16PW_HALT);
        e1 = s.live && t16pw_edge(s.cap1_q, capture_one_pin, s.cr1[`T16PW_CAPTURE_ONE_EDGE_SEL]);
        e2 = s.live && t16pw_edge(s.cap2_q, capture_two_pin, s.cr2[`T16PW_IEDG2]);
        ex = s.live && t16pw_edge(s.ext_q, ext_clock_pin, s.cr2[`T16PW_EXEDG]);

        // Timer tick from the prescaler or the external pin.
        if (!halted) begin
            n.pre = s.pre + 3'h1;
        end
        case (s.cr2[`T16PW_CC_MSB:`T16PW_CC_LSB])
            `T16PW_CC_DIV2: tick = (s.pre & `T16PW_MSK2) == `T16PW_LAST2;
            `T16PW_CC_DIV4: tick = (s.pre & `T16PW_MSK4) == `T16PW_LAST4;
            `T16PW_CC_DIV8: tick = (s.pre & `T16PW_MSK8) == `T16PW_LAST8;
            `T16PW_CC_EXT:  tick = ex;
            default:        tick = 1'b0;
        endcase
        tick = tick && !halted;

        // Software accesses come first so that hardware events win below.
        rd = rif.acc && !rif.wr;
        wr = rif.acc && rif.wr;
        case (rif.idx)
            `T16PW_IX_CR1: begin
                rdat = s.cr1;
                if (wr) begin
                    n.cr1 = rif.wdata;
                end
            end
            `T16PW_IX_CR2: begin
                rdat = s.cr2;
                if (wr) begin
                    n.cr2 = rif.wdata;
                end
            end
            `T16PW_IX_SR: begin
                rdat = {t16pw_flags(s), 3'h0};
                if (rd) begin
                    n.arm = t16pw_flags(s);
                end
            end
            `T16PW_IX_IC1H: begin
                rdat = t16pw_byte(s.ic1, 1'b1);
                if (rd) begin
                    n.ic1_inh = 1'b1;
                end
            end
            `T16PW_IX_IC1L: begin
                rdat = t16pw_byte(s.ic1, 1'b0);
                if (rd) begin
                    n.ic1_inh = 1'b0;
                end
                if (rif.acc && s.arm[`T16PW_F_CAPTURE_ONE_FLAG]) begin
                    n.capture_one_flag = 1'b0;
                    n.arm[`T16PW_F_CAPTURE_ONE_FLAG] = 1'b0;
                end
            end
            `T16PW_IX_IC2H: begin
                rdat = t16pw_byte(s.ic2, 1'b1);
                if (rd) begin
                    n.ic2_inh = 1'b1;
                end
            end
            `T16PW_IX_IC2L: begin
                rdat = t16pw_byte(s.ic2, 1'b0);
                if (rd) begin
                    n.ic2_inh = 1'b0;
                end
                if (rif.acc && s.arm[`T16PW_F_CAPTURE_TWO_FLAG]) begin
                    n.capture_two_flag = 1'b0;
                    n.arm[`T16PW_F_CAPTURE_TWO_FLAG] = 1'b0;
                end
            end
            `T16PW_IX_OC1H: begin
                rdat = t16pw_byte(s.oc1, 1'b1);
                if (wr) begin
                    n.oc1[15:8] = rif.wdata;
                    n.oc1_inh = 1'b1;
                end
            end
            `T16PW_IX_OC1L: begin
                rdat = t16pw_byte(s.oc1, 1'b0);
                if (wr) begin
                    n.oc1[7:0] = rif.wdata;
                    n.oc1_inh = 1'b0;
                end
                if (rif.acc && s.arm[`T16PW_F_COMPARE_ONE_FLAG]) begin
                    n.compare_one_flag = 1'b0;
                    n.arm[`T16PW_F_COMPARE_ONE_FLAG] = 1'b0;
                end
            end
            `T16PW_IX_OC2H: begin
                rdat = t16pw_byte(s.oc2, 1'b1);
                if (wr) begin
                    n.oc2[15:8] = rif.wdata;
                    n.oc2_inh = 1'b1;
                end
            end
            `T16PW_IX_OC2L: begin
                rdat = t16pw_byte(s.oc2, 1'b0);
                if (wr) begin
                    n.oc2[7:0] = rif.wdata;
                    n.oc2_inh = 1'b0;
                end
                if (rif.acc && s.arm[`T16PW_F_COMPARE_TWO_FLAG]) begin
                    n.compare_two_flag = 1'b0;
                    n.arm[`T16PW_F_COMPARE_TWO_FLAG] = 1'b0;
                end
            end
            `T16PW_IX_CNTH: begin
                rdat = t16pw_byte(s.cnt, 1'b1);
            end
            `T16PW_IX_CNTL: begin
                rdat = t16pw_byte(s.cnt, 1'b0);
                if (rif.acc && s.arm[`T16PW_F_TOF]) begin
                    n.overflow_flag = 1'b0;
                    n.arm[`T16PW_F_TOF] = 1'b0;
                end
            end
            `T16PW_IX_PWR: begin
                rdat = {5'h00, s.mask, s.pwr};
                if (wr) begin
                    n.mask = rif.wdata[`T16PW_P_MASK];
                    case (rif.wdata[1:0])
                        T16PW_WAIT: n.pwr = T16PW_WAIT;
                        T16PW_HALT: n.pwr = T16PW_HALT;
                        default:    n.pwr = T16PW_RUN;
                    endcase
                end
            end
            default: begin
                rdat = 8'h00;
            end
        endcase

        if (!halted) begin
            if (tick) begin
                n.cnt = s.cnt + 16'h0001;
                if (s.cnt == `T16PW_CNT_TOP) begin
                    n.overflow_flag = 1'b1;
                end
            end
            hit1 = tick && !s.oc1_inh && (s.cnt == s.oc1);
            hit2 = tick && !s.oc2_inh && (s.cnt == s.oc2);
            if (pwm) begin
                // Both compare flags stay untouched here.
                if (hit1) begin
                    n.out1 = s.cr1[`T16PW_LEVEL_AFTER_MATCH_ONE];
                end
                if (hit2) begin
                    n.out1 = s.cr1[`T16PW_LEVEL_AFTER_MATCH_TWO];
                    n.cnt = `T16PW_RELOAD;
                    n.capture_one_flag = 1'b1;
                end
            end else if (single_pulse_select) begin
                if (hit1) begin
                    n.out1 = s.cr1[`T16PW_LEVEL_AFTER_MATCH_ONE];
                end
                if (hit2) begin
                    n.compare_two_flag = 1'b1;
                end
                if (e1) begin
                    n.cnt = `T16PW_RELOAD;
                    n.out1 = s.cr1[`T16PW_LEVEL_AFTER_MATCH_TWO];
                    n.capture_one_flag = 1'b1;
                    n.ic1 = `T16PW_TRIG_CAP;
                end
            end else begin
                if (hit1) begin
                    n.compare_one_flag = 1'b1;
                    n.out1 = s.cr1[`T16PW_LEVEL_AFTER_MATCH_ONE];
                end
                if (hit2) begin
                    n.compare_two_flag = 1'b1;
                    n.out2 = s.cr1[`T16PW_LEVEL_AFTER_MATCH_TWO];
                end
                if (s.cr1[`T16PW_FOLV1]) begin
                    n.out1 = s.cr1[`T16PW_LEVEL_AFTER_MATCH_ONE];
                end
                if (s.cr1[`T16PW_FOLV2]) begin
                    n.out2 = s.cr1[`T16PW_LEVEL_AFTER_MATCH_TWO];
                end
                if (e1 && !s.ic1_inh) begin
                    n.capture_one_flag = 1'b1;
                    n.ic1 = s.cnt;
                end
            end
            if (e2 && !s.ic2_inh) begin
                n.capture_two_flag = 1'b1;
                n.ic2 = s.cnt;
            end
        end else begin
            // In halt the capture one pin is disconnected in the pulse modes; in run it is the one pulse trigger.
            if (e1 && !pwm && !single_pulse_select) begin
                n.harm1 = 1'b1;
            end
            if (e2) begin
                n.harm2 = 1'b1;
            end
            if (halt_wake) begin
                n.pwr = T16PW_RUN;
                n.harm1 = 1'b0;
                n.harm2 = 1'b0;
                if (s.harm1 || (e1 && !pwm && !single_pulse_select)) begin
                    n.capture_one_flag = 1'b1;
                    n.ic1 = s.cnt;
                end
                if (s.harm2 || e2) begin
                    n.capture_two_flag = 1'b1;
                    n.ic2 = s.cnt;
                end
            end
        end

        n.irq = !n.mask && (
            (n.cr1[`T16PW_CAPTURE_IRQ_ENABLE] && (n.capture_one_flag || n.capture_two_flag)) ||
            (n.cr1[`T16PW_COMPARE_IRQ_ENABLE] && (n.compare_one_flag || n.compare_two_flag)) ||
            (n.cr1[`T16PW_OVERFLOW_IRQ_ENABLE] && n.overflow_flag));
        if (s.pwr == T16PW_WAIT && n.pwr == T16PW_WAIT && n.irq) begin
            n.pwr = T16PW_RUN;
            n.wake = 1'b1;
        end
        rif.rdata = rdat;
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s <= '0;
            s.cr1 <= `T16PW_CR_RST;
            s.cr2 <= `T16PW_CR_RST;
            s.oc1 <= `T16PW_OC_RST;
            s.oc2 <= `T16PW_OC_RST;
            s.pwr <= T16PW_RUN;
        end else begin
            s <= n;
        end
    end

    assign compare_one_pin = s.out1;
    assign compare_one_pin_oe = s.cr2[`T16PW_COMPARE_ONE_PIN_ENABLE];
    assign compare_two_pin = s.out2;
    assign compare_two_pin_oe = s.cr2[`T16PW_OC2E];
    assign timer_irq = s.irq;
    assign wake_req = s.wake;
    assign hresp = 1'b0;
endmodule

// >>> verification/t16pw_timer_assertions.sv
`timescale 1ns/1ps
`include "t16pw_cfg.svh"
module t16pw_timer_chk (
    input wire logic        clock,
    input wire logic        rst,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        halt_wake,
    input wire logic        compare_one_pin,
    input wire logic        timer_irq,
    input wire logic        wake_req
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    logic       ph_q, dn_q, w_q, hv_q;
    logic [5:0] ix_q;
    logic [7:0] cr1_q, cr2_q, pw_q, cl_q;
    wire take   = hsel && htrans[1] && hready;
    wire sr_rd  = dn_q && !w_q && ix_q == `T16PW_IX_SR;
    wire cnt_rd = dn_q && !w_q && ix_q == `T16PW_IX_CNTL;
    wire eqlv   = cr2_q[5:4] != 2'b00 && cr1_q[0] == cr1_q[2];
    // Shadows of the control words follow the bus so rules can be judged at the ports.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            {ph_q, dn_q, w_q, hv_q, ix_q, cr1_q, cr2_q, pw_q, cl_q} <= '0;
        end else begin
            ph_q <= take;
            dn_q <= ph_q;
            if (take) begin
                w_q  <= hwrite;
                ix_q <= haddr[7:2];
            end
            if (ph_q && w_q && ix_q == `T16PW_IX_CR1) cr1_q <= hwdata[7:0];
            if (ph_q && w_q && ix_q == `T16PW_IX_CR2) cr2_q <= hwdata[7:0];
            if (ph_q && w_q && ix_q == `T16PW_IX_PWR) begin
                pw_q <= hwdata[7:0];
            end else if (wake_req || (halt_wake && pw_q[1:0] == 2'b11)) begin
                pw_q[1:0] <= 2'b00;
            end
            if (pw_q[1:0] != 2'b11) begin
                hv_q <= 1'b0;
            end else if (cnt_rd) begin
                hv_q <= 1'b1;
                cl_q <= hrdata[7:0];
            end
        end
    end
    sequence s_addr; hsel && htrans[1] && hready; endsequence
    sequence s_data; !hreadyout ##1 hreadyout; endsequence
    property p_okay; hresp == 1'b0; endproperty
    a_okay: assert property (p_okay) else $error("bus response not okay");
    property p_wait; s_addr |=> s_data; endproperty
    a_wait: assert property (p_wait) else $error("data phase timing wrong");
    property p_pwm_flags; sr_rd && cr2_q[4] |-> hrdata[6] == 1'b0 && hrdata[3] == 1'b0; endproperty
    a_pwm_flags: assert property (p_pwm_flags) else $error("compare flag set in pwm");
    property p_const;
        eqlv && compare_one_pin == cr1_q[0] && !ph_q && !dn_q |=> compare_one_pin == $past(cr1_q[0]);
    endproperty
    a_const: assert property (p_const) else $error("compare pin moved with equal levels");
    property p_irq_off; (cr1_q[7:5] == 3'b000 || pw_q[2]) && !dn_q |-> !timer_irq; endproperty
    a_irq_off: assert property (p_irq_off) else $error("interrupt while gated off");
    property p_wake_in; pw_q[1:0] == 2'b01 && timer_irq |-> ##[0:2] wake_req; endproperty
    a_wake_in: assert property (p_wake_in) else $error("no wake from wait");
    property p_wake_src; wake_req |-> pw_q[1:0] == 2'b01; endproperty
    a_wake_src: assert property (p_wake_src) else $error("wake outside wait");
    property p_frozen; cnt_rd && hv_q && pw_q[1:0] == 2'b11 |-> hrdata[7:0] == cl_q; endproperty
    a_frozen: assert property (p_frozen) else $error("counter moved in halt");
endmodule
bind t16pw_timer t16pw_timer_chk u_chk (.clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .halt_wake(halt_wake),
    .compare_one_pin(compare_one_pin), .timer_irq(timer_irq), .wake_req(wake_req));

// >>> verification/t16pw_load.sv
`timescale 1ns/1ps
module t16pw_load (
    input  wire logic       clock,
    input  wire logic       fire1,
    input  wire logic       fire2,
    input  wire logic       compare_one_pin,
    output logic            capture_one_pin,
    output logic            capture_two_pin,
    output logic      [7:0] high_len
);
    logic [7:0] run = 8'h00;
    // Trigger lines rest low, as with a pull-down, and pulse while requested.
    initial begin
        capture_one_pin = 1'b0;
        capture_two_pin = 1'b0;
        high_len = 8'h00;
    end
    // The load reports the length in clocks of the last complete high level.
    always @(posedge clock) begin
        capture_one_pin <= fire1;
        capture_two_pin <= fire2;
        if (compare_one_pin === 1'b1) begin
            run <= run + 8'h01;
        end else if (run != 8'h00) begin
            high_len <= run;
            run <= 8'h00;
        end
    end
endmodule

// >>> verification/testbench.sv
`timescale 1ns/1ps
`include "t16pw_cfg.svh"
module testbench;
    logic        clock, rst, hreadyout, cap1, cap2, pin1, pin2, oe1, oe2, irq, wake;
    logic        fire1 = 1'b0, fire2 = 1'b0, halt_wake = 1'b0, hwrite = 1'b0;
    logic        woke = 1'b0, ext = 1'b0;
    logic [1:0]  htrans = 2'b00;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic [7:0]  high_len, r, c;
    int          n_mismatch = 0, compares = 0, cyc = 0;

    t16pw_timer DUT (.clock(clock), .rst(rst), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(), .capture_one_pin(cap1), .capture_two_pin(cap2),
        .ext_clock_pin(ext), .halt_wake(halt_wake), .compare_one_pin(pin1),
        .compare_one_pin_oe(oe1), .compare_two_pin(pin2), .compare_two_pin_oe(oe2),
        .timer_irq(irq), .wake_req(wake));
    t16pw_load u_load (.clock(clock), .fire1(fire1), .fire2(fire2), .compare_one_pin(pin1),
        .capture_one_pin(cap1), .capture_two_pin(cap2), .high_len(high_len));

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (wake === 1'b1) woke <= 1'b1;
        if (cyc == 20000) begin
            n_mismatch++;
            print_verdict;
        end
    end
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic bus(input logic [5:0] ix, input logic w, input logic [7:0] d);
        haddr <= {24'h0, ix, 2'b00};
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge clock); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= {24'h0, d};
        do @(posedge clock); while (hreadyout !== 1'b1);
        r = hrdata[7:0];
    endtask
    task automatic rd(input logic [5:0] ix, input logic [7:0] e, input string nm);
        bus(ix, 1'b0, 8'h00);
        chk(nm, e, r);
    endtask
    task automatic fire(input logic two);
        if (two) fire2 <= 1'b1;
        else fire1 <= 1'b1;
        repeat (3) @(posedge clock);
        fire1 <= 1'b0;
        fire2 <= 1'b0;
        repeat (3) @(posedge clock);
    endtask
    task automatic t_opm;
        rd(`T16PW_IX_OC1H, 8'h80, "compare one reset");
        bus(`T16PW_IX_OC1H, 1'b1, 8'h00);
        bus(`T16PW_IX_OC1L, 1'b1, 8'h05);
        bus(`T16PW_IX_CR1, 1'b1, 8'h06);
        bus(`T16PW_IX_CR2, 1'b1, 8'ha4);
        bus(`T16PW_IX_OC2H, 1'b1, 8'h00);
        bus(`T16PW_IX_OC2L, 1'b1, 8'h03);
        fire(1'b0);
        repeat (60) @(posedge clock);
        compares++;
        if (high_len < 8'd18 || high_len > 8'd20) begin
            n_mismatch++;
            $display("ERROR pulse length expected 18 to 20 seen %0d", high_len);
        end
        chk("pin enables", 8'h01, {6'h0, oe2, oe1});
        chk("compare two pin", 8'h00, {7'h0, pin2});
        rd(`T16PW_IX_IC1H, 8'hff, "trigger capture high");
        rd(`T16PW_IX_IC1L, 8'hfd, "trigger capture low");
        rd(`T16PW_IX_SR, 8'ha8, "pulse flags");
        $display("test one pulse done");
    endtask
    task automatic t_pwm;
        bus(`T16PW_IX_OC1L, 1'b1, 8'h60);
        bus(`T16PW_IX_OC2H, 1'b1, 8'h00);
        bus(`T16PW_IX_OC2L, 1'b1, 8'h70);
        bus(`T16PW_IX_CR1, 1'b1, 8'h01);
        bus(`T16PW_IX_CR2, 1'b1, 8'hb4);
        repeat (600) @(posedge clock);
        chk("pwm high time", 8'd32, high_len);
        fire(1'b1);
        rd(`T16PW_IX_SR, 8'hb0, "pwm flags");
        bus(`T16PW_IX_CR1, 1'b1, 8'h00);
        repeat (300) @(posedge clock);
        chk("constant level", 8'h00, {7'h0, pin1});
        bus(`T16PW_IX_OC1H, 1'b1, 8'h00);
        bus(`T16PW_IX_OC2H, 1'b1, 8'h00);
        bus(`T16PW_IX_CR2, 1'b1, 8'h00);
        bus(`T16PW_IX_IC2L, 1'b0, 8'h00);
        repeat (500) @(posedge clock);
        rd(`T16PW_IX_SR, 8'ha0, "flags after clear");
        $display("test pwm done");
    endtask
    task automatic t_power;
        bus(`T16PW_IX_CR2, 1'b1, 8'h06);
        bus(`T16PW_IX_PWR, 1'b1, 8'h03);
        bus(`T16PW_IX_CNTL, 1'b0, 8'h00);
        c = r;
        repeat (20) @(posedge clock);
        rd(`T16PW_IX_CNTL, c, "count in halt");
        fire(1'b1);
        halt_wake <= 1'b1;
        @(posedge clock);
        halt_wake <= 1'b0;
        bus(`T16PW_IX_SR, 1'b0, 8'h00);
        chk("capture two after halt", 8'h01, {7'h0, r[4]});
        rd(`T16PW_IX_IC2L, c, "count captured at exit");
        bus(`T16PW_IX_IC1L, 1'b0, 8'h00);
        bus(`T16PW_IX_CR1, 1'b1, 8'h80);
        bus(`T16PW_IX_PWR, 1'b1, 8'h01);
        fire(1'b1);
        chk("wake seen", 8'h01, {7'h0, woke});
        rd(`T16PW_IX_PWR, 8'h00, "state after wake");
        chk("interrupt on", 8'h01, {7'h0, irq});
        bus(`T16PW_IX_PWR, 1'b1, 8'h04);
        repeat (2) @(posedge clock);
        chk("interrupt masked", 8'h00, {7'h0, irq});
        $display("test power done");
    endtask
    task automatic t_clock;
        bus(`T16PW_IX_CR2, 1'b1, 8'h08);
        bus(`T16PW_IX_CNTL, 1'b0, 8'h00);
        c = r;
        // The two counter samples lie exactly 80 clocks apart.
        repeat (77) @(posedge clock);
        rd(`T16PW_IX_CNTL, c + 8'd10, "divide by eight");
        bus(`T16PW_IX_CR2, 1'b1, 8'h0d);
        bus(`T16PW_IX_CNTL, 1'b0, 8'h00);
        c = r;
        repeat (5) begin
            ext <= 1'b1;
            @(posedge clock);
            ext <= 1'b0;
            @(posedge clock);
        end
        rd(`T16PW_IX_CNTL, c + 8'd5, "external clock");
        $display("test clock done");
    endtask
    initial begin
        rst = 1'b1;
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        t_opm;
        t_pwm;
        t_power;
        t_clock;
        print_verdict;
    end
endmodule
